/* File: cids_pkg.sv */
// Shared constants and operation codes of the instruction execute block
package cids_pkg;
  localparam int          CIDS_W        = 16;      // Core word width
  localparam logic [2:0]  CIDS_LEN2     = 3'h2;    // Short instruction, bytes
  localparam logic [2:0]  CIDS_LEN4     = 3'h4;    // Long instruction, bytes
  localparam logic [15:0] CIDS_RST_WORD = 16'h0000; // Data outputs after reset
  localparam logic [6:0]  CIDS_RST_TRAP = 7'h00;   // Trap number after reset
  localparam logic [15:0] CIDS_STEP1    = 16'h0001; // Pointer step, variant 1
  localparam logic [15:0] CIDS_STEP2    = 16'h0002; // Pointer step, variant 2

  // Operation codes handed over by the fetch stage (binary codes fixed)
  typedef enum logic [4:0] {
    CIDS_ADD   = 5'h00, CIDS_ADDC  = 5'h01, CIDS_MUL   = 5'h02, CIDS_MULU  = 5'h03,
    CIDS_DIV   = 5'h04, CIDS_DIVU  = 5'h05, CIDS_DIVL  = 5'h06, CIDS_DIVLU = 5'h07,
    CIDS_CMPD1 = 5'h08, CIDS_CMPD2 = 5'h09, CIDS_CMPI1 = 5'h0a, CIDS_CMPI2 = 5'h0b,
    CIDS_NORM  = 5'h0c, CIDS_JB    = 5'h0d, CIDS_JBC   = 5'h0e, CIDS_JNB   = 5'h0f,
    CIDS_JNBS  = 5'h10, CIDS_PDOWN = 5'h11, CIDS_BFH   = 5'h12, CIDS_BFL   = 5'h13,
    CIDS_CTXSW = 5'h14, CIDS_PUSH_AND_CALL = 5'h15, CIDS_MOVBS = 5'h16, CIDS_MOVBZ = 5'h17,
    CIDS_ARITHMETIC_RIGHT_SHIFT  = 5'h18, CIDS_TRAP  = 5'h19, CIDS_BMOV  = 5'h1a, CIDS_BMOVN = 5'h1b,
    CIDS_MAC   = 5'h1c, CIDS_MACLS = 5'h1d
  } cids_op_t;
endpackage

/* File: cids_exec.sv */
// Execute stage for decoded core instructions, one result per accepted operation
// Function
// (RULE1) Add with/without carry, word or byte
// (RULE2) Signed/unsigned 16x16 multiply, two bytes
// (RULE3) Short divide low register by register
// (RULE4) Long divide register pair by register
// (RULE5) Compare, then decrement pointer by 1/2
// (RULE6) Compare, then increment pointer by 1/2
// (RULE7) Normalize count into another register
// (RULE8) Branch if bit set, optionally clear
// (RULE9) Branch if bit clear, optionally set
// (RULE10) Power-down opcode legal, does nothing
// (RULE11) Masked high/low byte field modify
// (RULE12) Push register, then load new value
// (RULE13) Push register, then call absolute
// (RULE14) Byte to word, sign or zero
// (RULE15) Right shift keeping the sign
// (RULE16) Trap enters routine by immediate number
// (RULE17) Copy bit, plain or inverted
// (RULE18) Coprocessor instructions are four bytes
// (RULE19) Encodings come from the full definition
module cids_exec
  import cids_pkg::*;
(
  input  wire logic             sys_clk,      // System clock
  input  wire logic             resetn,       // Async reset, active low
  input  wire logic             op_valid,     // Decoded operation present
  input  wire cids_pkg::cids_op_t op_code,    // Operation code
  input  wire logic [2:0]       op_len,       // Instruction length in bytes
  input  wire logic             op_byte,      // Byte operand form
  input  wire logic [15:0]      opnd_a,       // First operand
  input  wire logic [15:0]      opnd_b,       // Second operand / register
  input  wire logic [15:0]      md_hi_in,     // Multiply/divide high half
  input  wire logic [15:0]      md_lo_in,     // Multiply/divide low half
  input  wire logic             carry_in,     // Carry flag
  input  wire logic             bit_in,       // Addressed bit value
  input  wire logic [7:0]       mask_in,      // Bit field mask
  input  wire logic [7:0]       imm_in,       // Immediate byte
  input  wire logic [15:0]      tgt_in,       // Branch or call target
  output logic                  done_r,       // Operation finished pulse
  output logic                  illegal_r,    // Unknown code or bad length
  output logic [15:0]           res_r,        // Result or low product word
  output logic                  res_we_r,     // Write result to register
  output logic [15:0]           md_hi_r,      // High product / remainder
  output logic                  md_we_r,      // Write register pair
  output logic [15:0]           ptr_r,        // Stepped pointer register
  output logic                  ptr_we_r,     // Write stepped pointer
  output logic                  carry_r,      // Carry or borrow
  output logic                  zero_r,       // Zero / equal
  output logic                  div_err_r,    // Divide by zero
  output logic                  branch_r,     // Relative branch taken
  output logic                  call_r,       // Subroutine call
  output logic [15:0]           tgt_r,        // Target for branch or call
  output logic                  push_r,       // Stack push request
  output logic [15:0]           push_data_r,  // Word to push
  output logic                  bit_we_r,     // Write addressed bit
  output logic                  bit_val_r,    // Value of written bit
  output logic                  trap_r,       // Enter service routine
  output logic [6:0]            trap_num_r,   // Trap number
  output logic                  mac_r         // Forward to coprocessor
);

  // Next values of every output flop
  logic        done_nxt, illegal_nxt, res_we_nxt, md_we_nxt, ptr_we_nxt;
  logic        carry_nxt, zero_nxt, div_err_nxt, branch_nxt, call_nxt;
  logic        push_nxt, bit_we_nxt, bit_val_nxt, trap_nxt, mac_nxt;
  logic [15:0] res_nxt, md_hi_nxt, ptr_nxt, tgt_nxt, push_data_nxt;
  logic [6:0]  trap_num_nxt;
  // Arithmetic helpers
  logic        legal, sgn, dsgn, vsgn;  // Code known, signed form, operand signs
  logic [1:0]  lmask;                   // Lengths this code allows, {four, two}
  logic [16:0] sum;                     // Adder with carry out
  logic [31:0] prod, dvd, dmag, q, r;   // Product and divide terms
  logic [15:0] vmag;                    // Divisor magnitude

  // Allowed lengths as {four, two}; unknown codes allow none
  function automatic logic [1:0] len_mask(input cids_op_t c);
    unique case (c)
      CIDS_ADD, CIDS_ADDC, CIDS_CMPD1, CIDS_CMPD2, CIDS_CMPI1, CIDS_CMPI2,
      CIDS_MOVBS, CIDS_MOVBZ: len_mask = 2'h3;
      CIDS_MUL, CIDS_MULU, CIDS_DIV, CIDS_DIVU, CIDS_DIVL, CIDS_DIVLU,
      CIDS_NORM, CIDS_ARITHMETIC_RIGHT_SHIFT, CIDS_TRAP: len_mask = 2'h1;
      CIDS_JB, CIDS_JBC, CIDS_JNB, CIDS_JNBS, CIDS_PDOWN, CIDS_BFH, CIDS_BFL,
      CIDS_CTXSW, CIDS_PUSH_AND_CALL, CIDS_BMOV, CIDS_BMOVN,
      CIDS_MAC, CIDS_MACLS: len_mask = 2'h2; // RULE18
      default: len_mask = 2'h0;
    endcase
  endfunction

  // Leading zeros before the top one; zero word counts nothing
  function automatic logic [15:0] norm_cnt(input logic [15:0] v);
    logic [15:0] c;
    logic        f;
    c = 16'h0000;
    f = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) f = 1'b1;
      else if (!f) c = c + 16'h0001;
    end
    if (v == 16'h0000) c = 16'h0000;
    return c;
  endfunction

  // Execute one operation; everything lands in flops the next edge
  always_comb begin
    done_nxt = 1'b0;  illegal_nxt = 1'b0; res_we_nxt = 1'b0; md_we_nxt = 1'b0;
    ptr_we_nxt = 1'b0; div_err_nxt = 1'b0; branch_nxt = 1'b0; call_nxt = 1'b0;
    push_nxt = 1'b0;  bit_we_nxt = 1'b0;  trap_nxt = 1'b0;   mac_nxt = 1'b0;
    carry_nxt = carry_r; zero_nxt = zero_r; bit_val_nxt = bit_val_r;
    res_nxt = res_r;  md_hi_nxt = md_hi_r; ptr_nxt = ptr_r;   tgt_nxt = tgt_r;
    push_data_nxt = push_data_r; trap_num_nxt = trap_num_r;
    legal = 1'b1;
    lmask = len_mask(op_code);
    sgn   = 1'b0;
    sum   = {1'b0, opnd_a} + {1'b0, opnd_b} + {16'h0000, (op_code == CIDS_ADDC) & carry_in}; // RULE1
    // Sign-extended operands give the right low 32 bits either way
    if (op_code == CIDS_MUL)
      prod = {{16{opnd_a[15]}}, opnd_a} * {{16{opnd_b[15]}}, opnd_b}; // RULE2
    else
      prod = {16'h0000, opnd_a} * {16'h0000, opnd_b};
    // Divide on magnitudes, then fix signs; one wide combinational divider
    sgn  = (op_code == CIDS_DIV) || (op_code == CIDS_DIVL);
    if (op_code == CIDS_DIVL || op_code == CIDS_DIVLU)
      dvd = {md_hi_in, md_lo_in}; // RULE4
    else
      dvd = {sgn ? {16{md_lo_in[15]}} : 16'h0000, md_lo_in}; // RULE3
    dsgn = sgn & dvd[31];
    vsgn = sgn & opnd_b[15];
    dmag = dsgn ? (32'h0 - dvd) : dvd;
    vmag = vsgn ? (16'h0 - opnd_b) : opnd_b;
    if (vmag == 16'h0000) begin
      q = 32'h0;
      r = 32'h0;
    end else begin
      q = dmag / {16'h0000, vmag};
      r = dmag % {16'h0000, vmag};
    end
    if (dsgn ^ vsgn) q = 32'h0 - q;
    if (dsgn) r = 32'h0 - r;
    if (op_valid) begin
      done_nxt = 1'b1;
      unique case (op_code)
        // Byte form only changes the low byte, carry from bit 7
        CIDS_ADD, CIDS_ADDC: begin
          res_we_nxt = 1'b1;
          res_nxt    = op_byte ? {opnd_a[15:8], sum[7:0]} : sum[15:0]; // RULE1
          // Carry into bit 8 recovered from the word adder; a compare fails on b=ff with carry
          carry_nxt  = op_byte ? (sum[8] ^ opnd_a[8] ^ opnd_b[8])
                               : sum[16];
          zero_nxt   = op_byte ? (sum[7:0] == 8'h00) : (sum[15:0] == 16'h0000);
        end
        CIDS_MUL, CIDS_MULU: begin
          md_we_nxt = 1'b1; // RULE2
          res_nxt   = prod[15:0];
          md_hi_nxt = prod[31:16];
          zero_nxt  = (prod == 32'h0);
        end
        CIDS_DIV, CIDS_DIVU, CIDS_DIVL, CIDS_DIVLU: begin
          // Zero divisor leaves the pair alone and flags it
          div_err_nxt = (vmag == 16'h0000); // RULE3 RULE4
          md_we_nxt   = (vmag != 16'h0000);
          res_nxt     = q[15:0];
          md_hi_nxt   = r[15:0];
        end
        CIDS_CMPD1, CIDS_CMPD2, CIDS_CMPI1, CIDS_CMPI2: begin
          zero_nxt   = (opnd_a == opnd_b);
          carry_nxt  = (opnd_b < opnd_a);
          ptr_we_nxt = 1'b1;
          unique case (op_code)
            CIDS_CMPD1: ptr_nxt = opnd_b - CIDS_STEP1; // RULE5
            CIDS_CMPD2: ptr_nxt = opnd_b - CIDS_STEP2; // RULE5
            CIDS_CMPI1: ptr_nxt = opnd_b + CIDS_STEP1; // RULE6
            default:    ptr_nxt = opnd_b + CIDS_STEP2; // RULE6
          endcase
        end
        CIDS_NORM: begin
          res_we_nxt = 1'b1;
          res_nxt    = norm_cnt(opnd_a); // RULE7
          zero_nxt   = (opnd_a == 16'h0000);
        end
        // Bit side effect only when the branch is taken
        CIDS_JB, CIDS_JBC: begin
          branch_nxt  = bit_in; // RULE8
          tgt_nxt     = tgt_in;
          bit_we_nxt  = bit_in & (op_code == CIDS_JBC);
          bit_val_nxt = 1'b0;
        end
        CIDS_JNB, CIDS_JNBS: begin
          branch_nxt  = !bit_in; // RULE9
          tgt_nxt     = tgt_in;
          bit_we_nxt  = !bit_in & (op_code == CIDS_JNBS);
          bit_val_nxt = 1'b1;
        end
        CIDS_PDOWN: ; // RULE10
        // Masked bits of one byte take the immediate, others stay
        CIDS_BFH: begin
          res_we_nxt = 1'b1;
          res_nxt    = {(opnd_a[15:8] & ~mask_in) | (imm_in & mask_in), opnd_a[7:0]}; // RULE11
        end
        CIDS_BFL: begin
          res_we_nxt = 1'b1;
          res_nxt    = {opnd_a[15:8], (opnd_a[7:0] & ~mask_in) | (imm_in & mask_in)}; // RULE11
        end
        CIDS_CTXSW: begin
          push_nxt      = 1'b1; // RULE12
          push_data_nxt = opnd_a;
          res_we_nxt    = 1'b1;
          res_nxt       = opnd_b;
        end
        CIDS_PUSH_AND_CALL: begin
          push_nxt      = 1'b1; // RULE13
          push_data_nxt = opnd_a;
          call_nxt      = 1'b1;
          tgt_nxt       = tgt_in;
        end
        CIDS_MOVBS, CIDS_MOVBZ: begin
          res_we_nxt = 1'b1;
          res_nxt    = {(op_code == CIDS_MOVBS) ? {8{opnd_a[7]}} : 8'h00, opnd_a[7:0]}; // RULE14
        end
        CIDS_ARITHMETIC_RIGHT_SHIFT: begin
          res_we_nxt = 1'b1;
          res_nxt    = 16'($signed(opnd_a) >>> opnd_b[3:0]); // RULE15
        end
        CIDS_TRAP: begin
          trap_nxt     = 1'b1; // RULE16
          trap_num_nxt = imm_in[6:0];
        end
        CIDS_BMOV, CIDS_BMOVN: begin
          bit_we_nxt  = 1'b1;
          bit_val_nxt = bit_in ^ (op_code == CIDS_BMOVN); // RULE17
        end
        CIDS_MAC, CIDS_MACLS: mac_nxt = 1'b1; // RULE18
        default: legal = 1'b0;
      endcase
      // Bad code or length: report, and suppress every write strobe; carry and zero still update on a bad length, hold on a bad code
      if (!legal || !((op_len == CIDS_LEN2 && lmask[0]) ||
                      (op_len == CIDS_LEN4 && lmask[1]))) begin // RULE19
        illegal_nxt = 1'b1;
        res_we_nxt = 1'b0; md_we_nxt = 1'b0; ptr_we_nxt = 1'b0; div_err_nxt = 1'b0;
        branch_nxt = 1'b0; call_nxt = 1'b0; push_nxt = 1'b0;  bit_we_nxt = 1'b0;
        trap_nxt = 1'b0;   mac_nxt = 1'b0;
      end
    end
  end

  // Output registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      done_r <= 1'b0; illegal_r <= 1'b0; res_we_r <= 1'b0; md_we_r <= 1'b0;
      ptr_we_r <= 1'b0; carry_r <= 1'b0; zero_r <= 1'b0; div_err_r <= 1'b0;
      branch_r <= 1'b0; call_r <= 1'b0; push_r <= 1'b0; bit_we_r <= 1'b0;
      bit_val_r <= 1'b0; trap_r <= 1'b0; mac_r <= 1'b0;
      res_r <= CIDS_RST_WORD; md_hi_r <= CIDS_RST_WORD; ptr_r <= CIDS_RST_WORD;
      tgt_r <= CIDS_RST_WORD; push_data_r <= CIDS_RST_WORD; trap_num_r <= CIDS_RST_TRAP;
    end else begin
      done_r <= done_nxt; illegal_r <= illegal_nxt; res_we_r <= res_we_nxt; md_we_r <= md_we_nxt;
      ptr_we_r <= ptr_we_nxt; carry_r <= carry_nxt; zero_r <= zero_nxt; div_err_r <= div_err_nxt;
      branch_r <= branch_nxt; call_r <= call_nxt; push_r <= push_nxt; bit_we_r <= bit_we_nxt;
      bit_val_r <= bit_val_nxt; trap_r <= trap_nxt; mac_r <= mac_nxt;
      res_r <= res_nxt; md_hi_r <= md_hi_nxt; ptr_r <= ptr_nxt;
      tgt_r <= tgt_nxt; push_data_r <= push_data_nxt; trap_num_r <= trap_num_nxt;
    end
  end

  // Checks tying each effect to the operation that caused it
  add_result_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE1
    (op_valid && op_code == CIDS_ADDC && !op_byte && op_len == CIDS_LEN4) |=>
      res_we_r && res_r == 16'($past(opnd_a) + $past(opnd_b) + {15'h0, $past(carry_in)}))
    else $error("add with carry result wrong");
  mul_product_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE2
    (op_valid && op_code == CIDS_MULU && op_len == CIDS_LEN2) |=>
      md_we_r && {md_hi_r, res_r} == {16'h0, $past(opnd_a)} * {16'h0, $past(opnd_b)})
    else $error("unsigned product wrong");
  div_zero_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE3
    (op_valid && op_code inside {CIDS_DIV, CIDS_DIVU, CIDS_DIVL, CIDS_DIVLU} && op_len == CIDS_LEN2 &&
     opnd_b == 16'h0) |=>
      div_err_r && !md_we_r)
    else $error("divide by zero not flagged");
  cmp_step_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE5
    (op_valid && op_code == CIDS_CMPD2 && op_len == CIDS_LEN2) |=>
      ptr_we_r && ptr_r == $past(opnd_b) - 16'h0002 && zero_r == ($past(opnd_a) == $past(opnd_b)))
    else $error("compare and decrement wrong");
  jbc_clear_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE8
    (op_valid && op_code == CIDS_JBC && op_len == CIDS_LEN4 && bit_in) |=>
      branch_r && bit_we_r && !bit_val_r ##1 !branch_r || $past(op_valid))
    else $error("bit jump with clear wrong");
  pdown_quiet_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE10
    (op_valid && op_code == CIDS_PDOWN && op_len == CIDS_LEN4) |=>
      done_r && !illegal_r && !res_we_r && !branch_r && !push_r && !trap_r && !bit_we_r)
    else $error("power down opcode had an effect");
  ctx_push_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE12
    (op_valid && op_code == CIDS_CTXSW && op_len == CIDS_LEN4) |=>
      push_r && push_data_r == $past(opnd_a) && res_we_r && res_r == $past(opnd_b))
    else $error("context switch wrong");
  trap_num_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE16
    (op_valid && op_code == CIDS_TRAP && op_len == CIDS_LEN2) |=>
      trap_r && trap_num_r == $past(imm_in[6:0]))
    else $error("trap number wrong");
  mac_length_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE18
    (op_valid && op_code == CIDS_MAC && op_len == CIDS_LEN2) |=> illegal_r && !mac_r)
    else $error("short coprocessor instruction accepted");
  arithmetic_right_shift_sign_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE15
    (op_valid && op_code == CIDS_ARITHMETIC_RIGHT_SHIFT && op_len == CIDS_LEN2 && opnd_a[15]) |=> res_r[15])
    else $error("sign lost in arithmetic shift");
endmodule

/* File: cids_fetch_model.sv */
// Fetch-stage model that hands decoded operations to the execute block
module cids_fetch_model
  import cids_pkg::*;
(
  output logic               op_valid, // Operation present
  output cids_pkg::cids_op_t op_code,  // Operation code
  output logic [2:0]         op_len,   // Length in bytes
  output logic               op_byte,  // Byte form
  output logic [15:0]        opnd_a,   // First operand
  output logic [15:0]        opnd_b,   // Second operand
  output logic [15:0]        md_hi_in, // Pair high half
  output logic [15:0]        md_lo_in, // Pair low half
  output logic               carry_in, // Carry flag
  output logic               bit_in,   // Addressed bit
  output logic [7:0]         mask_in,  // Field mask
  output logic [7:0]         imm_in,   // Immediate byte
  output logic [15:0]        tgt_in    // Target address
);
  timeunit 1ns;
  timeprecision 1ps;
  // Known values from time zero
  initial begin
    op_valid = 1'b0;
    op_code  = CIDS_ADD;
    {op_len, op_byte, opnd_a, opnd_b, md_hi_in, md_lo_in} = '0;
    {carry_in, bit_in, mask_in, imm_in, tgt_in} = '0;
  end
  // Fields flip while idle, so stale operands never pass for fresh ones
  task automatic idle();
    op_valid = 1'b0;
    op_code  = cids_op_t'(~op_code);
    {op_len, op_byte, opnd_a, opnd_b} = ~{op_len, op_byte, opnd_a, opnd_b};
    {md_hi_in, md_lo_in, carry_in, bit_in} = ~{md_hi_in, md_lo_in, carry_in, bit_in};
    {mask_in, imm_in, tgt_in} = ~{mask_in, imm_in, tgt_in};
  endtask
  // One operation, presented just after a rising edge by the caller
  task automatic drive(input cids_op_t c, input logic [2:0] l, input logic bf, input logic [15:0] a, b, hi, lo,
                       input logic cy, bt, input logic [7:0] m, im, input logic [15:0] t);
    op_valid = 1'b1;
    op_code  = c;
    {op_len, op_byte, opnd_a, opnd_b, md_hi_in, md_lo_in} = {l, bf, a, b, hi, lo};
    {carry_in, bit_in, mask_in, imm_in, tgt_in} = {cy, bt, m, im, t};
  endtask
endmodule

/* File: cids_exec_bench.sv */
// Self-checking bench for the instruction execute block
module cids_exec_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import cids_pkg::*;
  typedef struct packed {
    logic [15:0] res, hi, ptr;
    logic        c, z, bv;
    logic [6:0]  tn;
    logic [9:0]  st;  // md,ptr,branch,call,push,bit,trap,mac,illegal,diverr
  } cids_exp_t;
  logic sys_clk, resetn, op_valid, op_byte, carry_in, bit_in;
  cids_op_t op_code;
  logic [2:0] op_len;
  logic [15:0] opnd_a, opnd_b, md_hi_in, md_lo_in, tgt_in, res_r, md_hi_r, ptr_r, tgt_r, push_data_r;
  logic [7:0] mask_in, imm_in;
  logic done_r, illegal_r, res_we_r, md_we_r, ptr_we_r, carry_r, zero_r, div_err_r, branch_r, call_r;
  logic push_r, bit_we_r, bit_val_r, trap_r, mac_r;
  logic [6:0] trap_num_r;
  int n_fail = 0;
  int checks = 0;
  cids_fetch_model u_fetch (.op_valid(op_valid), .op_code(op_code), .op_len(op_len), .op_byte(op_byte),
    .opnd_a(opnd_a), .opnd_b(opnd_b), .md_hi_in(md_hi_in), .md_lo_in(md_lo_in), .carry_in(carry_in),
    .bit_in(bit_in), .mask_in(mask_in), .imm_in(imm_in), .tgt_in(tgt_in));
  cids_exec u_dut (.sys_clk(sys_clk), .resetn(resetn), .op_valid(op_valid), .op_code(op_code), .op_len(op_len),
    .op_byte(op_byte), .opnd_a(opnd_a), .opnd_b(opnd_b), .md_hi_in(md_hi_in), .md_lo_in(md_lo_in),
    .carry_in(carry_in), .bit_in(bit_in), .mask_in(mask_in), .imm_in(imm_in), .tgt_in(tgt_in),
    .done_r(done_r), .illegal_r(illegal_r), .res_r(res_r), .res_we_r(res_we_r), .md_hi_r(md_hi_r),
    .md_we_r(md_we_r), .ptr_r(ptr_r), .ptr_we_r(ptr_we_r), .carry_r(carry_r), .zero_r(zero_r),
    .div_err_r(div_err_r), .branch_r(branch_r), .call_r(call_r), .tgt_r(tgt_r), .push_r(push_r),
    .push_data_r(push_data_r), .bit_we_r(bit_we_r), .bit_val_r(bit_val_r), .trap_r(trap_r),
    .trap_num_r(trap_num_r), .mac_r(mac_r));
  // 200 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Inputs move a fixed 1 ns after the rising edge
  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask
  // Single comparison point
  task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Allowed instruction lengths per operation
  function automatic logic len_ok(cids_op_t c, logic [2:0] l);
    case (c)
      CIDS_ADD, CIDS_ADDC, CIDS_CMPD1, CIDS_CMPD2, CIDS_CMPI1, CIDS_CMPI2, CIDS_MOVBS, CIDS_MOVBZ:
        return l == 3'h2 || l == 3'h4;
      CIDS_MUL, CIDS_MULU, CIDS_DIV, CIDS_DIVU, CIDS_DIVL, CIDS_DIVLU, CIDS_NORM, CIDS_ARITHMETIC_RIGHT_SHIFT, CIDS_TRAP:
        return l == 3'h2;
      default: return (5'(c) <= 5'h1d) && l == 3'h4;
    endcase
  endfunction
  function automatic logic [2:0] pick_len(cids_op_t c);
    pick_len = len_ok(c, 3'h2) ? 3'h2 : 3'h4;
    if (len_ok(c, 3'h2) && len_ok(c, 3'h4) && $urandom % 2 == 1) pick_len = 3'h4;
  endfunction
  // Reference behaviour of one operation
  function automatic cids_exp_t predict(cids_op_t c, logic [2:0] l, logic bf, logic [15:0] a, b, hi, lo,
                                        logic cy, bt, logic [7:0] m, im);
    cids_exp_t e;
    logic [31:0] w;
    logic [8:0] s;
    int n;
    e = '0;
    n = 0;
    if (!len_ok(c, l)) begin
      e.st = 10'h002;
      return e;
    end
    case (c)
      CIDS_ADD, CIDS_ADDC: begin
        s = 9'(a[7:0]) + 9'(b[7:0]) + 9'(c == CIDS_ADDC && cy);
        w = 32'(a) + 32'(b) + 32'(c == CIDS_ADDC && cy);
        {e.c, e.res} = bf ? {s[8], a[15:8], s[7:0]} : w[16:0];
      end
      CIDS_MUL: {e.hi, e.res} = $signed(a) * $signed(b);
      CIDS_MULU: {e.hi, e.res} = 32'(a) * 32'(b);
      CIDS_DIV: {e.hi, e.res} = {16'($signed(lo) % $signed(b)), 16'($signed(lo) / $signed(b))};
      CIDS_DIVU: {e.hi, e.res} = {lo % b, lo / b};
      CIDS_DIVL: {e.hi, e.res} = {16'($signed({hi, lo}) % $signed(b)), 16'($signed({hi, lo}) / $signed(b))};
      CIDS_DIVLU: {e.hi, e.res} = {16'({hi, lo} % 32'(b)), 16'({hi, lo} / 32'(b))};
      CIDS_CMPD1, CIDS_CMPD2, CIDS_CMPI1, CIDS_CMPI2: begin
        {e.z, e.c} = {a == b, b < a};
        w[15:0] = (c == CIDS_CMPD1 || c == CIDS_CMPI1) ? CIDS_STEP1 : CIDS_STEP2;
        e.ptr = (c == CIDS_CMPD1 || c == CIDS_CMPD2) ? b - w[15:0] : b + w[15:0];
      end
      CIDS_NORM: begin
        if (a != 16'h0) while (a[15 - n] == 1'b0) n++;
        e.res = 16'(n);
      end
      CIDS_JB, CIDS_JBC: e.st[7] = bt;
      CIDS_JNB, CIDS_JNBS: e.st[7] = ~bt;
      CIDS_BFH: e.res = {(a[15:8] & ~m) | (im & m), a[7:0]};
      CIDS_BFL: e.res = {a[15:8], (a[7:0] & ~m) | (im & m)};
      CIDS_CTXSW: e.res = b;
      CIDS_MOVBS: e.res = {{8{a[7]}}, a[7:0]};
      CIDS_MOVBZ: e.res = {8'h00, a[7:0]};
      CIDS_ARITHMETIC_RIGHT_SHIFT: e.res = $signed(a) >>> b[3:0];
      CIDS_BMOV, CIDS_BMOVN: e.bv = (c == CIDS_BMOVN) ? ~bt : bt;
      default: ;
    endcase
    if (c inside {CIDS_MUL, CIDS_MULU, CIDS_DIV, CIDS_DIVU, CIDS_DIVL, CIDS_DIVLU}) e.st[9] = 1'b1;
    if (c inside {CIDS_DIV, CIDS_DIVU, CIDS_DIVL, CIDS_DIVLU} && b == 16'h0) e.st[9:0] = 10'h001;
    e.st[8] = c inside {CIDS_CMPD1, CIDS_CMPD2, CIDS_CMPI1, CIDS_CMPI2};
    e.st[6] = c == CIDS_PUSH_AND_CALL;
    e.st[5] = c inside {CIDS_PUSH_AND_CALL, CIDS_CTXSW};
    e.st[4] = (e.st[7] && c inside {CIDS_JBC, CIDS_JNBS}) || c inside {CIDS_BMOV, CIDS_BMOVN};
    if (c == CIDS_JNBS) e.bv = 1'b1;
    e.st[3] = c == CIDS_TRAP;
    e.tn = im[6:0];
    e.st[2] = c inside {CIDS_MAC, CIDS_MACLS};
    return e;
  endfunction
  // Issue one operation, check its single-cycle answer, optionally leave a gap
  task automatic run(input cids_op_t c, input logic [2:0] l, input logic bf, input logic [15:0] a, b, hi, lo,
                     input logic cy, bt, input logic [7:0] m, im, input logic [15:0] t, input logic gap);
    cids_exp_t e;
    e = predict(c, l, bf, a, b, hi, lo, cy, bt, m, im);
    u_fetch.drive(c, l, bf, a, b, hi, lo, cy, bt, m, im, t);
    step();
    chk("done", done_r, 1);
    chk("strobes", {md_we_r, ptr_we_r, branch_r, call_r, push_r, bit_we_r, trap_r, mac_r, illegal_r,
        div_err_r}, e.st);
    if (e.st[7] || e.st[6]) chk("target", tgt_r, t);
    if (e.st[4]) chk("bit_value", bit_val_r, e.bv);
    if (e.st[5]) chk("push_data", push_data_r, a);
    if (e.st[3]) chk("trap_number", trap_num_r, e.tn);
    if (e.st[1:0] == 2'b00) begin
      case (c)
        CIDS_ADD, CIDS_ADDC: chk("sum", {carry_r, res_r}, {e.c, e.res});
        CIDS_MUL, CIDS_MULU: chk("product", {md_hi_r, res_r}, {e.hi, e.res});
        CIDS_DIV, CIDS_DIVU: chk("short_div", {md_hi_r, res_r}, {e.hi, e.res});
        CIDS_DIVL, CIDS_DIVLU: chk("long_div", {md_hi_r, res_r}, {e.hi, e.res});
        CIDS_CMPD1, CIDS_CMPD2: chk("cmp_dec", {carry_r, zero_r, ptr_r}, {e.c, e.z, e.ptr});
        CIDS_CMPI1, CIDS_CMPI2: chk("cmp_inc", {carry_r, zero_r, ptr_r}, {e.c, e.z, e.ptr});
        CIDS_NORM: chk("norm_count", res_r, e.res);
        CIDS_BFH, CIDS_BFL: chk("bitfield", res_r, e.res);
        CIDS_CTXSW: chk("context", {res_we_r, res_r}, {1'b1, e.res});
        CIDS_MOVBS, CIDS_MOVBZ: chk("widen", res_r, e.res);
        CIDS_ARITHMETIC_RIGHT_SHIFT: chk("shift", res_r, e.res);
        default: ;
      endcase
    end
    if (gap) begin
      u_fetch.idle();
      step();
      chk("done_idle", done_r, 0);
    end
  endtask
  // Hang guard, well past the expected run length
  initial begin
    #60000;
    n_fail++;
    wrap_up();
  end
  initial begin
    cids_op_t c;
    resetn = 1'b0;
    void'($urandom(77774));
    repeat (12) @(posedge sys_clk);
    chk("reset_outputs", {done_r, illegal_r, res_r, md_hi_r}, 0);
    #1 resetn = 1'b1;
    for (int k = 0; k < 32; k++) begin
      c = cids_op_t'(5'(k));
      run(c, pick_len(c), 1'($urandom), 16'($urandom), 16'($urandom) | 16'h1, 16'($urandom), 16'($urandom),
          1'($urandom), 1'($urandom), 8'($urandom), 8'($urandom), 16'($urandom), 1'($urandom));
    end
    $display("test every_code done");
    run(CIDS_DIV, 3'h2, 0, 0, 16'h0, 0, 16'h1234, 0, 0, 0, 0, 0, 0);
    run(CIDS_DIVLU, 3'h2, 0, 0, 16'h0, 1, 16'h1234, 0, 0, 0, 0, 0, 0);
    run(CIDS_DIVL, 3'h2, 0, 0, 16'h2, 16'hffff, 16'hfff9, 0, 0, 0, 0, 0, 1);
    run(CIDS_NORM, 3'h2, 0, 16'h0, 0, 0, 0, 0, 0, 0, 0, 0, 0);
    run(CIDS_NORM, 3'h2, 0, 16'h1, 0, 0, 0, 0, 0, 0, 0, 0, 0);
    run(CIDS_ARITHMETIC_RIGHT_SHIFT, 3'h2, 0, 16'h8000, 16'hf, 0, 0, 0, 0, 0, 0, 0, 0);
    run(CIDS_JBC, 3'h4, 0, 0, 0, 0, 0, 0, 1, 0, 0, 16'hbeef, 0);
    run(CIDS_JBC, 3'h4, 0, 0, 0, 0, 0, 0, 0, 0, 0, 16'hbeef, 0);
    run(CIDS_JNBS, 3'h4, 0, 0, 0, 0, 0, 0, 0, 0, 0, 16'h1234, 0);
    run(CIDS_PDOWN, 3'h4, 0, 16'hffff, 16'hffff, 0, 0, 1, 1, 8'hff, 8'hff, 16'hffff, 0);
    run(CIDS_MUL, 3'h4, 0, 16'h7, 16'h9, 0, 0, 0, 0, 0, 0, 0, 0);
    run(CIDS_ADDC, 3'h2, 1, 16'h00ff, 16'h1, 0, 0, 1, 0, 0, 0, 0, 0);
    run(CIDS_CMPD2, 3'h4, 0, 16'h0, 16'h0, 0, 0, 0, 0, 0, 0, 0, 1);
    run(CIDS_ADD, 3'h2, 1, 16'h0010, 16'h00ff, 0, 0, 1, 0, 0, 0, 0, 0);
    run(CIDS_MAC, 3'h2, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0);
    $display("test corners done");
    repeat (400) begin
      c = cids_op_t'(5'($urandom_range(0, 29)));
      run(c, ($urandom % 20 == 0) ? 3'h3 : pick_len(c), 1'($urandom), 16'($urandom), 16'($urandom),
          16'($urandom), 16'($urandom), 1'($urandom), 1'($urandom), 8'($urandom), 8'($urandom),
          16'($urandom), 1'($urandom));
    end
    $display("test random done");
    wrap_up();
  end
endmodule
